// file: verilog/dio_pkg.sv
package dio_pkg;

  // Register offsets on the byte-wide host port.
  localparam logic [2:0] OFS_PORT_A_DATA = 3'h0;
  localparam logic [2:0] OFS_PORT_B_DATA = 3'h1;
  localparam logic [2:0] OFS_PORT_C_DATA = 3'h2;
  localparam logic [2:0] OFS_PORT_D_DATA = 3'h3;
  localparam logic [2:0] OFS_DIRECTION = 3'h4;
  localparam logic [2:0] OFS_INT_CTRL = 3'h5;
  localparam logic [2:0] OFS_SPARE_SIX = 3'h6;
  localparam logic [2:0] OFS_SPARE_SEVEN = 3'h7;

  // Field positions in the interrupt control and status register.
  localparam int POS_INT_ENABLE = 7;
  localparam int POS_INT_PENDING = 6;
  localparam int POS_TRIG_LO = 0;
  localparam int POS_TRIG_HI = 1;

  // Source bit within the first port.
  localparam int POS_INT_SOURCE = 0;

  // Reset values.
  localparam logic [3:0] RST_DIRECTION = 4'h0;
  localparam logic [7:0] RST_LATCH = 8'h00;
  localparam logic [1:0] RST_TRIGGER = 2'h0;
  localparam logic RST_INT_ENABLE = 1'b0;

  // Port count and width.
  localparam int NUM_PORTS = 4;
  localparam int PORT_WIDTH = 8;

  // Trigger selection codes.
  typedef enum logic [1:0] {
    TRIG_LOW_LEVEL = 2'h0,
    TRIG_HIGH_LEVEL = 2'h1,
    TRIG_FALLING = 2'h2,
    TRIG_RISING = 2'h3
  } trigger_t;

  // Pending-state machine states.
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_PENDING = 2'b10
  } irq_state_t;

endpackage

// file: verilog/port_slice.sv
module port_slice
  import dio_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  input wire logic dir_out,
  input wire logic [7:0] pin_in,
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe_n,
  output logic [7:0] read_value
);

  logic [7:0] latch_r;
  logic [7:0] latch_nxt;

  // The latch takes every host write regardless of direction.
  always_comb begin
    latch_nxt = latch_r;
    if (wr_en) begin
      latch_nxt = wr_data;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      latch_r <= RST_LATCH;
    end else begin
      latch_r <= latch_nxt;
    end
  end

  // Pins are driven active high from the latch only when an output.
  assign pin_out = latch_r;
  assign pin_oe_n = dir_out ? 8'h00 : 8'hff;

  // Inputs read the pin level; outputs read the driven byte.
  assign read_value = dir_out ? latch_r : pin_in;

endmodule

// file: verilog/irq_detect.sv
module irq_detect
  import dio_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic source,
  input wire logic [1:0] trigger,
  input wire logic read_clear,
  output logic event_hit,
  output logic pending
);

  logic prev_r;
  logic prev_nxt;
  logic armed_r;
  logic armed_nxt;
  irq_state_t state_r;
  irq_state_t state_nxt;
  logic level_hit;

  // Event detection for the selected trigger.
  always_comb begin
    level_hit = 1'b0;
    event_hit = 1'b0;
    unique case (trigger_t'(trigger))
      TRIG_LOW_LEVEL: begin
        level_hit = ~source;
      end
      TRIG_HIGH_LEVEL: begin
        level_hit = source;
      end
      TRIG_FALLING: begin
        event_hit = prev_r & ~source;
      end
      TRIG_RISING: begin
        event_hit = ~prev_r & source;
      end
    endcase
    // A level event fires only while armed, by reset or by a change of the input.
    if (level_hit && armed_r) begin
      event_hit = 1'b1;
    end
  end

  // Pending set wins over a read clear in the same cycle.
  always_comb begin
    prev_nxt = source;
    armed_nxt = armed_r;
    state_nxt = state_r;
    if (source != prev_r) begin
      armed_nxt = 1'b1;
    end
    if (level_hit && event_hit) begin
      armed_nxt = 1'b0;
    end
    unique case (state_r)
      ST_IDLE: begin
        if (event_hit) begin
          state_nxt = ST_PENDING;
        end
      end
      ST_PENDING: begin
        if (read_clear && !event_hit) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      prev_r <= 1'b0;
      armed_r <= 1'b1;
      state_r <= ST_IDLE;
    end else begin
      prev_r <= prev_nxt;
      armed_r <= armed_nxt;
      state_r <= state_nxt;
    end
  end

  assign pending = (state_r == ST_PENDING);

endmodule

// file: verilog/quad_byte_digital_io_port.sv
// Overview of operation
// - An input port reads one for each high pin and zero for each low pin.
// - An output port reads back the byte it is driving onto its pins.
// - Each port latch takes every write in either direction and keeps it.
// - Outputs are active high, driven from the latch while an output.
// - Port data bytes sit at offsets zero to three, each read/write.
// - Offset four bits 0 to 3 set each port's direction, one is output.
// - Reset clears every direction bit, so all ports come up as inputs.
// - The only interrupt source is bit 0 of the first port.
// - A level interrupt cannot fire again until the source input has changed.
// - Offset five bit 7 enables interrupts and is cleared by reset.
// - Offset five bit 6 reads pending; reading it clears pending unless a new event hits in that cycle.
module quad_byte_digital_io_port
  import dio_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [7:0] port_a_in,
  output logic [7:0] port_a_out,
  output logic [7:0] port_a_oe_n,
  input wire logic [7:0] port_b_in,
  output logic [7:0] port_b_out,
  output logic [7:0] port_b_oe_n,
  input wire logic [7:0] port_c_in,
  output logic [7:0] port_c_out,
  output logic [7:0] port_c_oe_n,
  input wire logic [7:0] port_d_in,
  output logic [7:0] port_d_out,
  output logic [7:0] port_d_oe_n,
  output logic irq_req
);

  logic [3:0] port_direction_bits_r;
  logic [3:0] port_direction_bits_nxt;
  logic interrupt_enable_r;
  logic interrupt_enable_nxt;
  logic [1:0] interrupt_trigger_select_r;
  logic [1:0] interrupt_trigger_select_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic [7:0] pin_in [NUM_PORTS];
  logic [7:0] pin_out [NUM_PORTS];
  logic [7:0] pin_oe_n [NUM_PORTS];
  logic [7:0] port_value [NUM_PORTS];
  logic interrupt_pending;
  logic status_read;

  // Gather the pin groups so the port slices can be generated.
  assign pin_in[0] = port_a_in;
  assign pin_in[1] = port_b_in;
  assign pin_in[2] = port_c_in;
  assign pin_in[3] = port_d_in;
  assign port_a_out = pin_out[0];
  assign port_b_out = pin_out[1];
  assign port_c_out = pin_out[2];
  assign port_d_out = pin_out[3];
  assign port_a_oe_n = pin_oe_n[0];
  assign port_b_oe_n = pin_oe_n[1];
  assign port_c_oe_n = pin_oe_n[2];
  assign port_d_oe_n = pin_oe_n[3];

  // One slice per port, each decoded at its own byte offset.
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    port_slice u_slice (
      .clock(clock),
      .sys_rst(sys_rst),
      .wr_en(reg_wr && (reg_addr == 3'(p))),
      .wr_data(reg_wdata),
      .dir_out(port_direction_bits_r[p]),
      .pin_in(pin_in[p]),
      .pin_out(pin_out[p]),
      .pin_oe_n(pin_oe_n[p]),
      .read_value(port_value[p])
    );
  end

  // A read of the status register clears the pending interrupt, unless a new event hits in the same cycle.
  assign status_read = reg_rd && (reg_addr == OFS_INT_CTRL);

  // Interrupt detection on the first port's bit 0 read value (latch when output).
  irq_detect u_irq (
    .clock(clock),
    .sys_rst(sys_rst),
    .source(port_value[0][POS_INT_SOURCE]),
    .trigger(interrupt_trigger_select_r),
    .read_clear(status_read),
    .event_hit(),
    .pending(interrupt_pending)
  );

  // Control register writes; only defined bits are stored.
  always_comb begin
    port_direction_bits_nxt = port_direction_bits_r;
    interrupt_enable_nxt = interrupt_enable_r;
    interrupt_trigger_select_nxt = interrupt_trigger_select_r;
    if (reg_wr) begin
      unique case (reg_addr)
        OFS_DIRECTION: begin
          port_direction_bits_nxt = reg_wdata[3:0];
        end
        OFS_INT_CTRL: begin
          interrupt_enable_nxt = reg_wdata[POS_INT_ENABLE];
          interrupt_trigger_select_nxt =
            reg_wdata[POS_TRIG_HI:POS_TRIG_LO];
        end
        default: begin
          port_direction_bits_nxt = port_direction_bits_r;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      port_direction_bits_r <= RST_DIRECTION;
      interrupt_enable_r <= RST_INT_ENABLE;
      interrupt_trigger_select_r <= RST_TRIGGER;
    end else begin
      port_direction_bits_r <= port_direction_bits_nxt;
      interrupt_enable_r <= interrupt_enable_nxt;
      interrupt_trigger_select_r <= interrupt_trigger_select_nxt;
    end
  end

  // Read mux; data stands only in the cycle after the read strobe.
  always_comb begin
    rdata_nxt = 8'h00;
    if (reg_rd) begin
      unique case (reg_addr)
        OFS_PORT_A_DATA: begin
          rdata_nxt = port_value[0];
        end
        OFS_PORT_B_DATA: begin
          rdata_nxt = port_value[1];
        end
        OFS_PORT_C_DATA: begin
          rdata_nxt = port_value[2];
        end
        OFS_PORT_D_DATA: begin
          rdata_nxt = port_value[3];
        end
        OFS_DIRECTION: begin
          rdata_nxt = {4'h0, port_direction_bits_r};
        end
        OFS_INT_CTRL: begin
          rdata_nxt[POS_INT_ENABLE] = interrupt_enable_r;
          rdata_nxt[POS_INT_PENDING] = interrupt_pending;
          rdata_nxt[POS_TRIG_HI:POS_TRIG_LO] = interrupt_trigger_select_r;
        end
        OFS_SPARE_SIX, OFS_SPARE_SEVEN: begin
          rdata_nxt = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata = rdata_r;

  // Request to the host while enabled and pending.
  assign irq_req = interrupt_enable_r && interrupt_pending;

endmodule

// file: tb/field_model.sv
module field_model (
  input wire logic [31:0] drv,
  input wire logic [31:0] out,
  input wire logic [31:0] oe_n,
  output logic [31:0] pin
);
  timeunit 1ns;
  timeprecision 1ns;
  // A driven pin shows the device level, a released one the field level.
  assign pin = (oe_n & drv) | (~oe_n & out);
endmodule

// file: tb/dio_properties.sv
module dio_checker
  import dio_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [7:0] port_a_out,
  input wire logic [7:0] port_a_oe_n,
  input wire logic [7:0] port_b_in,
  input wire logic [7:0] port_b_out,
  input wire logic [7:0] port_b_oe_n,
  input wire logic [7:0] port_d_oe_n,
  input wire logic irq_req
);
  timeunit 1ns;
  timeprecision 1ns;
  // All checks sample on the rising clock and rest during reset.
  default clocking @(posedge clock);
  endclocking
  default disable iff (sys_rst);
  property p_rst;
    $fell(sys_rst) |-> port_a_oe_n == 8'hff && port_d_oe_n == 8'hff
      && !irq_req;
  endproperty
  a_rst: assert property (p_rst) else $error("Reset state wrong.");
  property p_dir;
    reg_wr && reg_addr == OFS_DIRECTION
      |=> port_a_oe_n == {8{~$past(reg_wdata[0])}};
  endproperty
  a_dir: assert property (p_dir) else $error("Direction wrong.");
  property p_latch;
    reg_wr && reg_addr == OFS_PORT_A_DATA |=> port_a_out == $past(reg_wdata);
  endproperty
  a_latch: assert property (p_latch) else $error("Latch wrong.");
  property p_in;
    reg_rd && reg_addr == OFS_PORT_B_DATA && port_b_oe_n == 8'hff
      |=> reg_rdata == $past(port_b_in);
  endproperty
  a_in: assert property (p_in) else $error("Input read wrong.");
  property p_out;
    reg_rd && reg_addr == OFS_PORT_B_DATA && port_b_oe_n == 8'h00
      |=> reg_rdata == port_b_out;
  endproperty
  a_out: assert property (p_out) else $error("Output read wrong.");
  property p_spare;
    reg_rd && reg_addr[2:1] == 2'b11 |=> reg_rdata == 8'h00;
  endproperty
  a_spare: assert property (p_spare) else $error("Spare not 0.");
  property p_dirbits;
    reg_rd && reg_addr == OFS_DIRECTION |=> reg_rdata[7:4] == 4'h0;
  endproperty
  a_dirbits: assert property (p_dirbits) else $error("Bits not 0.");
  property p_intbits;
    reg_rd && reg_addr == OFS_INT_CTRL |=> reg_rdata[5:2] == 4'h0;
  endproperty
  a_intbits: assert property (p_intbits) else $error("Bits not 0.");
  property p_irq;
    reg_rd && reg_addr == OFS_INT_CTRL ##1 !reg_rdata[POS_INT_ENABLE]
      |-> !irq_req;
  endproperty
  a_irq: assert property (p_irq) else $error("Irq while off.");
endmodule

bind quad_byte_digital_io_port dio_checker u_chk (.clock, .sys_rst,
  .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .port_a_out,
  .port_a_oe_n, .port_b_in, .port_b_out, .port_b_oe_n, .port_d_oe_n,
  .irq_req);

// file: tb/test_quad_byte_digital_io_port.sv
module test_quad_byte_digital_io_port
  import dio_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic irq_req;
  logic [31:0] fld = 32'h0000_0001;
  wire logic [31:0] pin;
  wire logic [31:0] po;
  wire logic [31:0] pe;
  logic [7:0] lat [4] = '{default: 8'h00};
  logic [3:0] dir = 4'h0;
  int errors = 0;
  int compares = 0;
  int cyc = 0;
  // Free-running clock at 50 ns.
  always #25 clock = ~clock;
  quad_byte_digital_io_port u_dut (.clock, .sys_rst, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .irq_req,
    .port_a_in(pin[7:0]), .port_a_out(po[7:0]), .port_a_oe_n(pe[7:0]),
    .port_b_in(pin[15:8]), .port_b_out(po[15:8]), .port_b_oe_n(pe[15:8]),
    .port_c_in(pin[23:16]), .port_c_out(po[23:16]), .port_c_oe_n(pe[23:16]),
    .port_d_in(pin[31:24]), .port_d_out(po[31:24]), .port_d_oe_n(pe[31:24]));
  field_model u_fld (.drv(fld), .out(po), .oe_n(pe), .pin(pin));
  task automatic summarize();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    compares++;
    if (s !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rdc(input logic [2:0] a, input logic [7:0] e);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 chk("reg_rdata", e, reg_rdata);
  endtask
  // A port reads its latch when an output, its pins when an input.
  function automatic logic [7:0] port_exp(input int p);
    return dir[p] ? lat[p] : fld[p*8 +: 8];
  endfunction
  // Cuts a hung run short.
  always @(posedge clock) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      summarize();
    end
  end
  // Main sequence.
  initial begin
    logic [7:0] v;
    logic [2:0] a;
    logic [1:0] t;
    logic [1:0] tp;
    v = 8'($urandom(32'h4870));
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (2) begin
      for (int i = 4; i < 8; i++) rdc(3'(i), 8'h00);
      wr(OFS_DIRECTION, 8'hf0);
      wr(OFS_INT_CTRL, 8'h7c);
      wr(OFS_SPARE_SIX, 8'hff);
    end
    // Random writes to latches and directions, then every port checked.
    for (int k = 0; k < 40; k++) begin
      @(posedge clock) fld <= $urandom | 32'h1;
      a = 3'($urandom_range(4));
      v = 8'($urandom);
      wr(a, v);
      if (a == OFS_DIRECTION) dir = v[3:0];
      else lat[a] = v;
      for (int p = 0; p < 4; p++) begin
        rdc(3'(p), port_exp(p));
        chk("out", lat[p], po[p*8 +: 8]);
        chk("oe_n", {8{~dir[p]}}, pe[p*8 +: 8]);
      end
      rdc(OFS_DIRECTION, {4'h0, dir});
    end
    // Reset in mid-run clears latches, directions and any stale pending.
    @(posedge clock) sys_rst <= 1'b1;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    dir = RST_DIRECTION;
    lat = '{default: RST_LATCH};
    for (int p = 0; p < 4; p++) begin
      rdc(3'(p), port_exp(p));
      chk("out", RST_LATCH, po[p*8 +: 8]);
      chk("oe_n", 8'hff, pe[p*8 +: 8]);
    end
    for (int i = 4; i < 8; i++) rdc(3'(i), 8'h00);
    // Preset a latch while the port is an input, then turn it to output.
    v = 8'($urandom);
    wr(OFS_PORT_C_DATA, v);
    chk("pin", fld[23:16], pin[23:16]);
    wr(OFS_DIRECTION, 8'h04);
    chk("pin", v, pin[23:16]);
    // Each trigger mode: fire, mask, enable, clear, re-fire.
    wr(OFS_DIRECTION, 8'h00);
    tp = RST_TRIGGER;
    for (int m = 0; m < 4; m++) begin
      t = 2'(m);
      wr(OFS_INT_CTRL, {6'h0, tp});
      @(posedge clock) fld[0] <= ~t[0];
      wr(OFS_INT_CTRL, {6'h0, t});
      repeat (3) @(posedge clock);
      rdc(OFS_INT_CTRL, {6'h0, t});
      @(posedge clock) fld[0] <= t[0];
      repeat (3) @(posedge clock);
      chk("irq_req", 8'h00, {7'h0, irq_req});
      wr(OFS_INT_CTRL, {6'h20, t});
      chk("irq_req", 8'h01, {7'h0, irq_req});
      rdc(OFS_INT_CTRL, {2'b11, 4'h0, t});
      chk("irq_req", 8'h00, {7'h0, irq_req});
      rdc(OFS_INT_CTRL, {2'b10, 4'h0, t});
      @(posedge clock) fld[0] <= ~t[0];
      repeat (3) @(posedge clock);
      fld[0] <= t[0];
      repeat (3) @(posedge clock);
      rdc(OFS_INT_CTRL, {2'b11, 4'h0, t});
      tp = t;
    end
    summarize();
  end
endmodule
